// File: hdl/tpwm_timer.v
// Top of the 8-bit up-counting timer with period and PWM modes
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_regs.vh"

module tpwm_timer #(
    parameter PWM_RES_7BIT = 0,
    parameter N_EXT        = 7
) (
    input  wire                    clk_i,
    input  wire                    reset_n_i,
    input  wire [`TPWM_ADDR_W-1:0] addr_i,
    input  wire [7:0]              wdata_i,
    input  wire                    wr_i,
    input  wire                    rd_i,
    output reg  [7:0]              rdata_o,
    input  wire [N_EXT-1:0]        ext_src_i,
    output reg                     timer_out_o,
    output reg                     port_b_pin_two_o,
    output reg                     port_a_pin_three_o,
    output reg                     port_b_pin_four_o
);
    // ************************************************************
    // Registers and state
    // ************************************************************
    reg  [7:0] timer_control_reg;
    reg  [7:0] bound_value_reg;
    reg  [7:0] prescale_control_reg;
    reg  [7:0] counter_value_reg;
    reg        wave_reg;
    reg  [7:0] counter_next;
    reg        wave_next;
    reg  [7:0] res_max;
    reg  [7:0] rdata_next;
    wire       src_tick;
    wire       cnt_tick;
    wire       pwm_mode;
    wire       low_res;
    wire [1:0] pin_sel;
    wire [3:0] src_sel;
    wire [1:0] pre_sel;
    wire [4:0] scale_val;
    wire       cnt_wr;
    reg  [1:0] mode_sel;
    reg  [7:0] masked_cnt;
    reg  [7:0] masked_bound;
    reg        wrap_hit;
    reg        bound_hit;
    reg  [7:0] status_word;
    reg        pin_b2_next;
    reg        pin_a3_next;
    reg        pin_b4_next;

    // Resolution maxima; the 7-bit one replaces the 6-bit one by build option
    localparam [7:0] RES_MAX_8 = 8'hff;
    localparam [7:0] RES_MAX_7 = 8'h7f;
    localparam [7:0] RES_MAX_6 = 8'h3f;

    // Operating modes, binary coded
    localparam [1:0] MODE_PERIOD = 2'h0;
    localparam [1:0] MODE_PWM_HI = 2'h1;
    localparam [1:0] MODE_PWM_LO = 2'h2;

    // Register map on the plain port:
    //   0 timer_control    source 7:4, pin 3:2, PWM mode 1, spare 0
    //   1 bound_value      period bound or PWM duty bound
    //   2 prescale_control low resolution 7, prescale 6:5, scaler 4:0
    //   3 counter_value    live count; a write reloads it at once
    //   4 status           PWM mode 1, wave 0; read-only
    // Source code 0 stops the count, 1 is the system clock and
    // 2 to N_EXT+1 count rising edges of ext_src_i; higher codes also stop it.
    // The prescaler and scaler keep their phase while stopped, so the
    // first period after a restart may be short; later ones are exact.
    // Bound changes take effect at once; in period mode lower the bound
    // only while stopped, or the count runs on to 255 before it clears.

    assign pwm_mode = timer_control_reg[`TPWM_TC_PWM_BIT];
    assign low_res  = prescale_control_reg[`TPWM_PS_LOWRES_BIT];
    assign pin_sel  = timer_control_reg[`TPWM_TC_PIN_HI:`TPWM_TC_PIN_LO];
    assign src_sel   = timer_control_reg[`TPWM_TC_SRC_HI:`TPWM_TC_SRC_LO];
    assign pre_sel   = prescale_control_reg[`TPWM_PS_PRE_HI:`TPWM_PS_PRE_LO];
    assign scale_val = prescale_control_reg[`TPWM_PS_SCL_HI:`TPWM_PS_SCL_LO];

    // Decode used by the write path and the counter write strobe
    function sel_match;
        input [`TPWM_ADDR_W-1:0] a;
        input [`TPWM_ADDR_W-1:0] ofs;
        begin
            sel_match = (a == ofs);
        end
    endfunction

    // Highest count of the active PWM resolution
    function [7:0] res_limit;
        input lr;
        input opt7;
        begin
            if (!lr) begin
                res_limit = RES_MAX_8;
            end else if (opt7) begin
                res_limit = RES_MAX_7;
            end else begin
                res_limit = RES_MAX_6;
            end
        end
    endfunction

    // Pin routing decode, shared by the three pin drivers
    function pin_hit;
        input [1:0] sel;
        input [1:0] code;
        begin
            pin_hit = (sel == code);
        end
    endfunction

    // A counter write reaches the counter path, not the register file
    assign cnt_wr = wr_i && sel_match(addr_i, `TPWM_OFS_COUNTER_VALUE);

    // ************************************************************
    // Operating mode
    // ************************************************************
    always @* begin
        case ({pwm_mode, low_res})
            2'b10: begin
                mode_sel = MODE_PWM_HI;
            end
            2'b11: begin
                mode_sel = MODE_PWM_LO;
            end
            default: begin
                mode_sel = MODE_PERIOD;
            end
        endcase
    end

    // ************************************************************
    // Clock chain
    // ************************************************************
    tpwm_clk_src #(
        .N_EXT (N_EXT)
    ) u_src (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .sel_i     (src_sel),
        .ext_src_i (ext_src_i),
        .tick_o    (src_tick)
    );

    tpwm_divider u_div (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .tick_i    (src_tick),
        .pre_sel_i (pre_sel),
        .scale_i   (scale_val),
        .tick_o    (cnt_tick)
    );

    // ************************************************************
    // Counter and waveform
    // ************************************************************
    always @* begin
        // Period mode compares the full count, PWM only the low bits
        res_max      = res_limit(mode_sel == MODE_PWM_LO, PWM_RES_7BIT != 0);
        masked_cnt   = counter_value_reg & res_max;
        masked_bound = bound_value_reg & res_max;
        wrap_hit     = (masked_cnt == res_max);
        bound_hit    = (counter_value_reg == bound_value_reg);
    end

    always @* begin
        counter_next = counter_value_reg;
        wave_next    = wave_reg;
        if (cnt_tick) begin
            if (mode_sel != MODE_PERIOD) begin
                // A stale high bit cannot stretch a PWM period
                if (wrap_hit) begin
                    counter_next = 8'h00;
                end else begin
                    counter_next = masked_cnt + 8'h01;
                end
                // High while count <= bound, so bound at max never drops
                wave_next = ((counter_next & res_max) <= masked_bound);
            end else begin
                // Clear at bound; output toggles per bounded count
                if (bound_hit) begin
                    counter_next = 8'h00;
                    wave_next    = ~wave_reg;
                end else begin
                    counter_next = counter_value_reg + 8'h01;
                end
            end
        end
        // A software write wins over a tick in the same cycle
        if (cnt_wr) begin
            counter_next = wdata_i;
        end
    end

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            counter_value_reg <= 8'h00;
        end else begin
            counter_value_reg <= counter_next;
        end
    end

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            wave_reg <= 1'b0;
        end else begin
            wave_reg <= wave_next;
        end
    end

    // ************************************************************
    // Register write port
    // ************************************************************
    // Status has no storage, so writes to it fall through
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            timer_control_reg <= `TPWM_RST_TIMER_CONTROL;
        end else if (wr_i && sel_match(addr_i, `TPWM_OFS_TIMER_CONTROL)) begin
            timer_control_reg <= wdata_i;
        end
    end

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            bound_value_reg <= `TPWM_RST_BOUND_VALUE;
        end else if (wr_i && sel_match(addr_i, `TPWM_OFS_BOUND_VALUE)) begin
            bound_value_reg <= wdata_i;
        end
    end

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            prescale_control_reg <= `TPWM_RST_PRESCALE_CTRL;
        end else if (wr_i && sel_match(addr_i, `TPWM_OFS_PRESCALE_CTRL)) begin
            prescale_control_reg <= wdata_i;
        end
    end

    // ************************************************************
    // Read port: data valid the cycle after the strobe only
    // ************************************************************
    always @* begin
        status_word = {6'h00, pwm_mode, wave_reg};
        rdata_next  = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `TPWM_OFS_TIMER_CONTROL: begin
                    rdata_next = timer_control_reg;
                end
                `TPWM_OFS_BOUND_VALUE: begin
                    rdata_next = bound_value_reg;
                end
                `TPWM_OFS_PRESCALE_CTRL: begin
                    rdata_next = prescale_control_reg;
                end
                `TPWM_OFS_COUNTER_VALUE: begin
                    rdata_next = counter_value_reg;
                end
                `TPWM_OFS_STATUS: begin
                    rdata_next = status_word;
                end
                // Unmapped reads return zero
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    // ************************************************************
    // Pin routing
    // ************************************************************
    always @* begin
        pin_b2_next = 1'b0;
        pin_a3_next = 1'b0;
        pin_b4_next = 1'b0;
        // Unselected pins idle low; pin code zero keeps the wave internal
        if (pin_hit(pin_sel, `TPWM_PIN_B2)) begin
            pin_b2_next = wave_next;
        end
        if (pin_hit(pin_sel, `TPWM_PIN_A3)) begin
            pin_a3_next = wave_next;
        end
        if (pin_hit(pin_sel, `TPWM_PIN_B4)) begin
            pin_b4_next = wave_next;
        end
    end

    // ************************************************************
    // Output pins, all registered
    // ************************************************************
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rdata_next;
        end
    end

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            timer_out_o <= 1'b0;
        end else begin
            timer_out_o <= wave_next;
        end
    end

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            port_b_pin_two_o   <= 1'b0;
            port_a_pin_three_o <= 1'b0;
            port_b_pin_four_o  <= 1'b0;
        end else begin
            port_b_pin_two_o   <= pin_b2_next;
            port_a_pin_three_o <= pin_a3_next;
            port_b_pin_four_o  <= pin_b4_next;
        end
    end
endmodule
`default_nettype wire

// File: hdl/tpwm_regs.vh
// Register offsets, field positions, reset values, source and pin select codes of the 8-bit PWM timer
`ifndef TPWM_REGS_VH
`define TPWM_REGS_VH

// Register indices (byte addresses on the plain port)
`define TPWM_ADDR_W            4
`define TPWM_OFS_TIMER_CONTROL 4'h0
`define TPWM_OFS_BOUND_VALUE   4'h1
`define TPWM_OFS_PRESCALE_CTRL 4'h2
`define TPWM_OFS_COUNTER_VALUE 4'h3
`define TPWM_OFS_STATUS        4'h4

// timer_control fields
`define TPWM_TC_SRC_HI   7
`define TPWM_TC_SRC_LO   4
`define TPWM_TC_PIN_HI   3
`define TPWM_TC_PIN_LO   2
`define TPWM_TC_PWM_BIT  1
`define TPWM_TC_INV_BIT  0

// prescale_control fields
`define TPWM_PS_LOWRES_BIT 7
`define TPWM_PS_PRE_HI     6
`define TPWM_PS_PRE_LO     5
`define TPWM_PS_SCL_HI     4
`define TPWM_PS_SCL_LO     0

// Reset values
`define TPWM_RST_TIMER_CONTROL 8'h00
`define TPWM_RST_BOUND_VALUE   8'h00
`define TPWM_RST_PRESCALE_CTRL 8'h00

// Source select codes; zero stops the timer
`define TPWM_SRC_STOP   4'h0
`define TPWM_SRC_SYSCLK 4'h1

// Output pin select codes
`define TPWM_PIN_NONE   2'h0
`define TPWM_PIN_B2     2'h1
`define TPWM_PIN_A3     2'h2
`define TPWM_PIN_B4     2'h3

// Prescale ratios as shift counts: 1, 4, 16, 64
`define TPWM_PRE_MAX_LOG2 6

`endif

// File: hdl/tpwm_clk_src.v
// Source selection and edge detection for the timer's count source
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_regs.vh"

module tpwm_clk_src #(
    parameter N_EXT = 7
) (
    input  wire             clk_i,
    input  wire             reset_n_i,
    input  wire [3:0]       sel_i,
    input  wire [N_EXT-1:0] ext_src_i,
    output reg              tick_o
);
    reg [N_EXT-1:0] ext_prev_reg;
    reg             tick_next;
    integer         idx;

    // ************************************************************
    // Rising edge per source; system clock ticks every cycle
    // ************************************************************
    always @* begin
        tick_next = 1'b0;
        idx = sel_i - 2;
        if (sel_i == `TPWM_SRC_SYSCLK) begin
            tick_next = 1'b1;
        end else if (sel_i >= 4'h2 && idx < N_EXT) begin
            tick_next = ext_src_i[idx] & ~ext_prev_reg[idx];
        end
    end

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            ext_prev_reg <= {N_EXT{1'b0}};
            tick_o       <= 1'b0;
        end else begin
            ext_prev_reg <= ext_src_i;
            tick_o       <= tick_next;
        end
    end
endmodule
`default_nettype wire

// File: hdl/tpwm_divider.v
// Prescaler (1/4/16/64) followed by the scaler (value plus one)
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_regs.vh"

module tpwm_divider (
    input  wire       clk_i,
    input  wire       reset_n_i,
    input  wire       tick_i,
    input  wire [1:0] pre_sel_i,
    input  wire [4:0] scale_i,
    output wire       tick_o
);
    reg  [`TPWM_PRE_MAX_LOG2-1:0] pre_cnt_reg;
    reg  [4:0]                    scl_cnt_reg;
    wire [`TPWM_PRE_MAX_LOG2-1:0] pre_last;
    wire                          pre_tick;

    // Ratio 4^sel: last count is 0, 3, 15 or 63
    assign pre_last = (6'h01 << {pre_sel_i, 1'b0}) - 6'h01;
    assign pre_tick = tick_i && (pre_cnt_reg >= pre_last);
    assign tick_o   = pre_tick && (scl_cnt_reg >= scale_i);

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            pre_cnt_reg <= 6'h00;
            scl_cnt_reg <= 5'h00;
        end else if (tick_i) begin
            pre_cnt_reg <= pre_tick ? 6'h00 : pre_cnt_reg + 6'h01;
            if (pre_tick) begin
                scl_cnt_reg <= tick_o ? 5'h00 : scl_cnt_reg + 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/tpwm_timer_properties.sv
// Port assertions for the PWM timer
`timescale 1ns/1ps
`default_nettype none
module tpwm_timer_properties #(parameter N_EXT = 7) (
    input wire logic             clk_i,
    input wire logic             reset_n_i,
    input wire logic [3:0]       addr_i,
    input wire logic [7:0]       wdata_i,
    input wire logic             wr_i,
    input wire logic             rd_i,
    input wire logic [7:0]       rdata_o,
    input wire logic [N_EXT-1:0] ext_src_i,
    input wire logic             timer_out_o,
    input wire logic             port_b_pin_two_o,
    input wire logic             port_a_pin_three_o,
    input wire logic             port_b_pin_four_o
);
    // ****************
    // Bus and pin checks
    // ****************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence wr_rd(a, b);
        wr_i && addr_i == a ##1 rd_i && addr_i == b;
    endsequence
    rd_quiet_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
    unmapped_rd_a: assert property (rd_i && addr_i > 4'h4 |=> rdata_o == 8'h00) else $error("unmapped read");
    ctrl_back_a: assert property (wr_rd(4'h0, 4'h0) |=> rdata_o == $past(wdata_i, 2)) else $error("ctrl back");
    bound_back_a: assert property (wr_rd(4'h1, 4'h1) |=> rdata_o == $past(wdata_i, 2)) else $error("bound back");
    scale_back_a: assert property (wr_rd(4'h2, 4'h2) |=> rdata_o == $past(wdata_i, 2)) else $error("scale back");
    mode_flag_a: assert property (wr_rd(4'h0, 4'h4) |=> rdata_o[1] == $past(wdata_i[1], 2)) else $error("mode");
    one_pin_a: assert property ($onehot0({port_b_pin_two_o, port_a_pin_three_o, port_b_pin_four_o}))
        else $error("two pins driven");
    pin_wave_a: assert property (port_b_pin_two_o || port_a_pin_three_o || port_b_pin_four_o |-> timer_out_o)
        else $error("pin without wave");
endmodule
bind tpwm_timer tpwm_timer_properties #(.N_EXT(N_EXT)) u_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_src_i(ext_src_i),
    .timer_out_o(timer_out_o), .port_b_pin_two_o(port_b_pin_two_o),
    .port_a_pin_three_o(port_a_pin_three_o), .port_b_pin_four_o(port_b_pin_four_o));
`default_nettype wire

// File: dv/tpwm_timer_tb.sv
// Bench for the PWM timer
`timescale 1ns/1ps
`default_nettype none
module tpwm_timer_tb;
    logic       clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, pb2, pa3, pb4, wave;
    logic [3:0] addr_i = 0;
    logic [7:0] wdata_i = 0, rdata_o, d;
    logic [4:0] sc [4] = '{5'h00, 5'h02, 5'h1f, 5'h01};
    logic [7:0] pk [4] = '{8'h09, 8'h1f, 8'h00, 8'h00}, pp [4] = '{8'h00, 8'h80, 8'h20, 8'h80};
    int         ph [4] = '{10, 32, 4, 1}, pl [4] = '{246, 32, 1020, 63};
    int         error_cnt = 0, num_checks = 0, hi, lo, n, h [3];
    logic [6:0] ext = 0;
    logic       use7 = 0, wave7;
    wire        wsel = use7 ? wave7 : wave;
    tpwm_timer u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .ext_src_i(ext), .timer_out_o(wave), .port_b_pin_two_o(pb2),
        .port_a_pin_three_o(pa3), .port_b_pin_four_o(pb4));
    // Second build with the 7-bit resolution option, sharing the bus
    tpwm_timer #(.PWM_RES_7BIT(1)) u_dut7 (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(), .ext_src_i(ext), .timer_out_o(wave7),
        .port_b_pin_two_o(), .port_a_pin_three_o(), .port_b_pin_four_o());
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // ****************
    // Bus tasks and compares
    // ****************
    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s: expected %h, seen %h", w, e, g);
        end
    endtask
    task automatic chkn(input string w, input int e, input int g);
        num_checks++;
        if (g != e) begin
            error_cnt++;
            $display("Error %s: expected %0d, seen %0d", w, e, g);
        end
    endtask
    // Strobes stay up until the next task drops them, so calls run back to back
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        #1 d = rdata_o;
    endtask
    task automatic idle;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic waitv(input logic v, output int c);
        c = 0;
        while (wsel !== v && c < 20000) begin
            idle();
            c++;
        end
        if (c == 20000) begin
            chkn("wave wait", 0, c);
            tally_and_finish();
        end
    endtask
    task automatic meas;
        waitv(1'b0, n);
        waitv(1'b1, n);
        waitv(1'b0, hi);
        waitv(1'b1, lo);
    endtask
    // Stop first so a shrinking bound never leaves the count above it
    task automatic cfg(input logic [7:0] c, input logic [7:0] b, input logic [7:0] p);
        wr(4'h0, 8'h00);
        wr(4'h2, p);
        wr(4'h1, b);
        wr(4'h3, 8'h00);
        wr(4'h0, c);
        rd(4'h4);
        chk8("mode flag", {7'h00, c[1]}, {7'h00, d[1]});
        idle();
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1;
        for (int i = 0; i < 3; i++) begin
            rd(i[3:0]);
            chk8("reset", 8'h00, d);
            wr(i[3:0], 8'h5a ^ i[7:0]);
            rd(i[3:0]);
            chk8("readback", 8'h5a ^ i[7:0], d);
        end
        wr(4'h0, 8'h00);
        wr(4'h3, 8'h05);
        rd(4'h3);
        chk8("counter", 8'h05, d);
        rd(4'h5);
        chk8("unmapped", 8'h00, d);
        for (int i = 0; i < 4; i++) begin
            cfg(8'h18, 8'h03, {1'b0, i[1:0], sc[i]});
            meas();
            chkn("half high", 4 * (4 ** i) * (sc[i] + 1), hi);
            chkn("half low", 4 * (4 ** i) * (sc[i] + 1), lo);
        end
        for (int i = 0; i < 4; i++) begin
            cfg(8'h1a, pk[i], pp[i]);
            meas();
            chkn("pwm high", ph[i], hi);
            chkn("pwm low", pl[i], lo);
        end
        for (int i = 0; i < 2; i++) begin
            cfg(8'h1a, i ? 8'h3f : 8'hff, i ? 8'h80 : 8'h00);
            repeat (4) idle();
            n = 0;
            repeat (300) begin
                idle();
                n += (wave === 1'b1);
            end
            chkn("full high", 300, n);
        end
        use7 = 1'b1;
        cfg(8'h1a, 8'h1f, 8'h80);
        meas();
        chkn("pwm7 high", 32, hi);
        chkn("pwm7 low", 96, lo);
        use7 = 1'b0;
        for (int s = 0; s < 2; s++) begin
            cfg(s ? 8'h80 : 8'h20, 8'hff, 8'h00);
            repeat (5) begin
                ext <= s ? 7'h40 : 7'h01;
                idle();
                ext <= 7'h00;
                idle();
            end
            repeat (3) idle();
            rd(4'h3);
            chk8("ext count", 8'h05, d);
        end
        for (int p = 0; p < 4; p++) begin
            cfg({4'h1, p[1:0], 2'b00}, 8'h01, 8'h00);
            repeat (8) idle();
            h = '{0, 0, 0};
            repeat (8) begin
                idle();
                h[0] += (pb2 === 1'b1);
                h[1] += (pa3 === 1'b1);
                h[2] += (pb4 === 1'b1);
            end
            for (int k = 0; k < 3; k++) chkn("pin", (p == k + 1) ? 4 : 0, h[k]);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
